// ==== lfm_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module lfm_asserts import lfm_pkg::*; (
    // Bus lines
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic frame_n,
    input wire logic [3:0] host_lad_o,
    input wire logic host_lad_oe_n,
    input wire logic [3:0] dev_lad_o,
    input wire logic dev_lad_oe_n,
    input wire logic [3:0] lad
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ----
    // Turnaround shapes
    // ----
    sequence s_dev_open;
        $fell(dev_lad_oe_n) ##0 dev_lad_o == NIB_ONES;
    endsequence
    sequence s_dev_close;
        $rose(dev_lad_oe_n) ##0 frame_n && $past(frame_n) && $past(frame_n, 2);
    endsequence
    AST_NO_CONTENTION: assert property (host_lad_oe_n || dev_lad_oe_n)
        else $error("both ends drive the lines");
    AST_DEV_OPEN_ONES: assert property ($fell(dev_lad_oe_n) |-> dev_lad_o == NIB_ONES)
        else $error("device took the lines without ones");
    AST_DEV_REL_ONES: assert property (s_dev_close |-> $past(dev_lad_o) == NIB_ONES)
        else $error("device released without ones");
    AST_DEV_HOLDS: assert property (s_dev_open ##1 frame_n |-> !dev_lad_oe_n)
        else $error("device dropped the lines after taking them");
    AST_ABORT_RELEASE: assert property (!frame_n |-> ##[0:2] dev_lad_oe_n)
        else $error("device still drives under low frame");
    AST_HOST_FRAME_DRIVE: assert property (!frame_n |-> !host_lad_oe_n)
        else $error("host floats the lines under low frame");
    AST_HOST_REL_ONES: assert property ($rose(host_lad_oe_n) |-> $past(host_lad_o) == NIB_ONES)
        else $error("host released without ones");
    AST_FLOAT_AFTER_FRAME: assert property ($rose(frame_n) |-> dev_lad_oe_n [*8])
        else $error("device drives during the request fields");
endmodule : lfm_asserts
`default_nettype wire

// ==== lfm_buf.sv ====
`timescale 1ns/10ps
`default_nettype none
module lfm_buf #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);
    logic [W-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wr_ptr_ff;
    logic [PW-1:0] rd_ptr_ff;
    logic [PW:0] cnt_ff;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == LAST) ? '0 : p + 1'b1;
    endfunction : bump
    assign in_ready = (cnt_ff != FULL);
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem_ff[rd_ptr_ff];
    always_ff @(posedge clock) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst || flush) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) wr_ptr_ff <= bump(wr_ptr_ff);
            if (pop) rd_ptr_ff <= bump(rd_ptr_ff);
            cnt_ff <= cnt_ff + (PW + 1)'(push) - (PW + 1)'(pop);
        end
    end
endmodule : lfm_buf
`default_nettype wire

// ==== lfm_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module lfm_host #(
    parameter int SYNC_WAIT = lfm_pkg::SYNC_WAIT_CLKS,
    parameter int ABORT_LEN = lfm_pkg::ABORT_CLKS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Bus pins
    lfm_if.host bus,
    // Command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic [3:0] cmd_id,
    input wire logic [lfm_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [3:0] cmd_size,
    input wire logic [31:0] cmd_wdata,
    input wire logic abort_req,
    // Response
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic done,
    output logic fail
);
    import lfm_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    lfm_host_state_t state_ff;
    lfm_host_state_t nxt_state;
    logic wr_ff;
    logic [3:0] id_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [3:0] size_ff;
    logic [31:0] wdata_ff;
    logic [7:0] cnt_ff;
    logic [CNT_W-1:0] left_ff;
    logic [3:0] lo_ff;
    logic [7:0] rsp_data_ff;
    logic rsp_valid_ff;
    logic done_ff;
    logic fail_ff;

    wire [CNT_W-1:0] nbytes = size_bytes(size_ff);
    wire [7:0] last_wnib = 8'(({1'b0, nbytes} << 1) - 9'h001);
    wire sync_seen = (bus.lad == SYNC_READY);
    wire can_abort = (state_ff != H_IDLE) && (state_ff != H_ABORT);

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            H_IDLE: if (cmd_valid) nxt_state = H_START;
            H_START: nxt_state = H_ID; // [RULE_01]
            H_ID: nxt_state = H_ADDR; // [RULE_03]
            H_ADDR: if (cnt_ff == 8'(ADDR_NIBS - 1)) nxt_state = H_SIZE; // [RULE_04]
            H_SIZE: nxt_state = wr_ff ? H_WDATA : H_TAR0;
            H_WDATA: if (cnt_ff == last_wnib) nxt_state = H_TAR0; // [RULE_12]
            H_TAR0: nxt_state = H_TAR1; // [RULE_07] [RULE_13]
            H_TAR1: nxt_state = H_SYNC;
            H_SYNC: begin
                if (sync_seen) begin
                    nxt_state = wr_ff ? H_DTAR0 : H_RDATA;
                end else if (cnt_ff == 8'(SYNC_WAIT - 1)) begin
                    nxt_state = H_ABORT;
                end
            end
            H_RDATA: if (cnt_ff[0] && (left_ff == 8'h01)) nxt_state = H_DTAR0;
            H_DTAR0: nxt_state = H_DTAR1; // [RULE_11] [RULE_15]
            H_DTAR1: nxt_state = H_IDLE;
            H_ABORT: if (cnt_ff == 8'(ABORT_LEN - 1)) nxt_state = H_IDLE; // [RULE_18]
            default: nxt_state = H_IDLE;
        endcase
        if (abort_req && can_abort) nxt_state = H_ABORT; // [RULE_19]
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_ff <= H_IDLE;
            cnt_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= (nxt_state != state_ff) ? 8'h00 : cnt_ff + 8'h01;
            if ((state_ff == H_RDATA) && (nxt_state == H_RDATA)) cnt_ff <= cnt_ff + 8'h01;
        end
    end

    // ----------------------------------------
    // Command capture and read collection
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_ff <= 1'b0;
            id_ff <= 4'h0;
            addr_ff <= '0;
            size_ff <= 4'h0;
            wdata_ff <= 32'h0000_0000;
            left_ff <= '0;
            lo_ff <= 4'h0;
        end else begin
            if (cmd_valid && cmd_ready) begin
                wr_ff <= cmd_write;
                id_ff <= cmd_id;
                addr_ff <= cmd_addr;
                size_ff <= cmd_size;
                wdata_ff <= cmd_wdata;
            end
            if (state_ff == H_ADDR) addr_ff <= {addr_ff[ADDR_W-5:0], 4'h0};
            if (state_ff == H_WDATA) wdata_ff <= {4'h0, wdata_ff[31:4]};
            if (state_ff == H_SYNC) left_ff <= nbytes;
            if (state_ff == H_RDATA) begin
                if (!cnt_ff[0]) lo_ff <= bus.lad; // [RULE_16]
                if (cnt_ff[0]) left_ff <= left_ff - 8'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= 8'h00;
            done_ff <= 1'b0;
            fail_ff <= 1'b0;
        end else begin
            rsp_valid_ff <= (state_ff == H_RDATA) && cnt_ff[0];
            if ((state_ff == H_RDATA) && cnt_ff[0]) rsp_data_ff <= {bus.lad, lo_ff}; // [RULE_10]
            done_ff <= (state_ff == H_DTAR1);
            fail_ff <= (nxt_state == H_ABORT) && (state_ff != H_ABORT);
        end
    end

    assign cmd_ready = (state_ff == H_IDLE);
    assign rsp_valid = rsp_valid_ff;
    assign rsp_data = rsp_data_ff;
    assign done = done_ff;
    assign fail = fail_ff;

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    assign bus.frame_n = !((state_ff == H_START) || (state_ff == H_ABORT)); // [RULE_01] [RULE_18]
    assign bus.host_lad_oe_n = !((state_ff == H_START) || (state_ff == H_ID) || (state_ff == H_ADDR) ||
                                 (state_ff == H_SIZE) || (state_ff == H_WDATA) || (state_ff == H_TAR0) ||
                                 (state_ff == H_ABORT));
    assign bus.host_lad_o = (state_ff == H_START) ? (wr_ff ? START_WR : START_RD) :
                            (state_ff == H_ID) ? id_ff :
                            (state_ff == H_ADDR) ? addr_ff[ADDR_W-1:ADDR_W-4] :
                            (state_ff == H_SIZE) ? size_ff :
                            (state_ff == H_WDATA) ? wdata_ff[3:0] : // [RULE_12]
                            NIB_ONES; // [RULE_07] [RULE_13]
endmodule : lfm_host
`default_nettype wire

// ==== lfm_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface lfm_if;
    logic frame_n;
    logic [3:0] host_lad_o;
    logic host_lad_oe_n;
    logic [3:0] dev_lad_o;
    logic dev_lad_oe_n;
    logic [3:0] lad;
    // Undriven lines float high through the board pull-ups
    assign lad = !host_lad_oe_n ? host_lad_o : (!dev_lad_oe_n ? dev_lad_o : lfm_pkg::NIB_ONES);
    modport dev (input frame_n, input lad, output dev_lad_o, output dev_lad_oe_n);
    modport host (input lad, output frame_n, output host_lad_o, output host_lad_oe_n);
endinterface : lfm_if
`default_nettype wire

// ==== lfm_pkg.sv ====
package lfm_pkg;
    // ----------------------------------------
    // Field codes
    // ----------------------------------------
    localparam logic [3:0] START_RD = 4'hd;
    localparam logic [3:0] START_WR = 4'he;
    localparam logic [3:0] NIB_ONES = 4'hf;
    localparam logic [3:0] SYNC_READY = 4'h0;
    // ----------------------------------------
    // Field layout
    // ----------------------------------------
    localparam int ADDR_NIBS = 7;
    localparam int ADDR_W = 28;
    localparam int FLASH_SEL_BIT = 22;
    localparam int OFFS_W = 21;
    localparam int CNT_W = 8;
    localparam int WR_BYTES_MAX = 4;
    // ----------------------------------------
    // Host timing counts, in clocks
    // ----------------------------------------
    localparam int SYNC_WAIT_CLKS = 64;
    localparam int ABORT_CLKS = 4;
    // ----------------------------------------
    // State encodings
    // ----------------------------------------
    typedef enum logic [12:0] {
        ST_IDLE = 13'h0001, ST_START = 13'h0002, ST_ADDR = 13'h0004, ST_SIZE = 13'h0008,
        ST_RTAR0 = 13'h0010, ST_RTAR1 = 13'h0020, ST_RD_SYNC = 13'h0040, ST_RDATA = 13'h0080,
        ST_WDATA = 13'h0100, ST_WTAR0 = 13'h0200, ST_WTAR1 = 13'h0400, ST_WSYNC = 13'h0800,
        ST_TAR_OUT = 13'h1000
    } lfm_tgt_state_t;
    typedef enum logic [12:0] {
        H_IDLE = 13'h0001, H_START = 13'h0002, H_ID = 13'h0004, H_ADDR = 13'h0008,
        H_SIZE = 13'h0010, H_WDATA = 13'h0020, H_TAR0 = 13'h0040, H_TAR1 = 13'h0080,
        H_SYNC = 13'h0100, H_RDATA = 13'h0200, H_DTAR0 = 13'h0400, H_DTAR1 = 13'h0800,
        H_ABORT = 13'h1000
    } lfm_host_state_t;
    // ----------------------------------------
    // Size decode
    // ----------------------------------------
    function automatic logic [CNT_W-1:0] size_bytes(input logic [3:0] sz);
        size_bytes = 8'h01 << sz[2:0];
    endfunction : size_bytes
    function automatic logic size_ok(input logic [3:0] sz, input logic is_wr);
        size_ok = (sz == 4'h0) || (sz == 4'h1) || (sz == 4'h2) || (!is_wr && ((sz == 4'h4) || (sz == 4'h7)));
    endfunction : size_ok
endpackage : lfm_pkg

// ==== lfm_target.sv ====
// What this block does
// [RULE_01] Last START under low frame; 1101 reads
// [RULE_02] START 1110 writes; other STARTs ignored
// [RULE_03] Respond only when ID nibble matches straps
// [RULE_04] Seven address nibbles, MSB first, 28 bits
// [RULE_05] Read sizes 1,2,4,16,128 bytes only
// [RULE_06] Write sizes 1,2,4 bytes only
// [RULE_07] Host drives ones then releases, clock 11
// [RULE_08] Device starts driving in read clock 12
// [RULE_09] Ready sync 0000 in clock 13; waits in ST_RTAR1 for a buffered read byte, so clock 13 at earliest
// [RULE_10] Read data low nibble, lowest byte first
// [RULE_11] Device drives ones once, then releases
// [RULE_12] Host sends write data low nibble first
// [RULE_13] Host drives ones after last write nibble
// [RULE_14] Device takes lines, then ready sync 0000
// [RULE_15] After write sync, ones then release
// [RULE_16] Each nibble sampled on its rising edge
// [RULE_17] Frame low mid-cycle ends the cycle
// [RULE_18] Host abort: ones while frame low
// [RULE_19] Abort cancels only the current cycle
// [RULE_20] Bad size: reset, no operation, no answer
// [RULE_21] Unaligned multi-byte address forced to alignment
// [RULE_22] Bit 22 selects flash or registers
// [RULE_23] Valid cycle completes; busy blocks new write
// [RULE_24] After abort or ignore, float, await START
`timescale 1ns/10ps
`default_nettype none
module lfm_target (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Bus pins
    lfm_if.dev bus,
    // Straps
    input wire logic [3:0] device_select_straps,
    // Read request
    output logic rd_req,
    output logic rd_flash,
    output logic [lfm_pkg::OFFS_W-1:0] rd_offset,
    output logic [lfm_pkg::CNT_W-1:0] rd_count,
    // Read data
    input wire logic rd_valid,
    output logic rd_ready,
    input wire logic [7:0] rd_data,
    // Write data
    output logic wr_valid,
    input wire logic wr_ready,
    output logic wr_flash,
    output logic [lfm_pkg::OFFS_W-1:0] wr_offset,
    output logic [7:0] wr_data,
    // Status
    input wire logic prog_busy,
    output logic cyc_abort
);
    import lfm_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    lfm_tgt_state_t state_ff;
    lfm_tgt_state_t nxt_state;
    logic [3:0] id_meta_ff;
    logic [3:0] id_sync_ff;
    logic [3:0] start_ff;
    logic is_wr_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [3:0] nib_cnt_ff;
    logic [CNT_W-1:0] byte_cnt_ff;
    logic [CNT_W-1:0] left_ff;
    logic [CNT_W-1:0] push_cnt_ff;
    logic hi_ff;
    logic skip_ff;
    logic [8*WR_BYTES_MAX-1:0] wdata_ff;
    logic rd_req_ff;
    logic cyc_abort_ff;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire frame_low = !bus.frame_n;
    wire start_ok = (start_ff == START_RD) || (start_ff == START_WR);
    wire id_hit = (bus.lad == id_sync_ff);
    wire sz_ok = size_ok(bus.lad, is_wr_ff);
    wire [CNT_W-1:0] nbytes = size_bytes(bus.lad);
    wire [ADDR_W-1:0] align_mask = ~(ADDR_W'(nbytes) - 28'h0000001);
    wire [3:0] last_wnib = 4'(({1'b0, byte_cnt_ff} << 1) - 9'h001);
    wire busy_state = (state_ff != ST_IDLE) && (state_ff != ST_START);
    wire in_wr_push = (state_ff == ST_WDATA) || (state_ff == ST_WTAR0) || (state_ff == ST_WTAR1);
    wire [CNT_W-1:0] bytes_have = (state_ff == ST_WDATA) ? CNT_W'(nib_cnt_ff[3:1]) : byte_cnt_ff;
    wire pushed_all = skip_ff || (push_cnt_ff == byte_cnt_ff);
    wire buf_valid;
    wire [7:0] buf_data;
    wire buf_pop = (state_ff == ST_RDATA) && hi_ff;
    wire dev_drive = (state_ff == ST_RTAR1) || (state_ff == ST_RD_SYNC) || (state_ff == ST_RDATA) ||
                     (state_ff == ST_WTAR1) || (state_ff == ST_WSYNC) || (state_ff == ST_TAR_OUT);

    // ----------------------------------------
    // Strap synchroniser
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            id_meta_ff <= 4'h0;
            id_sync_ff <= 4'h0;
        end else begin
            id_meta_ff <= device_select_straps;
            id_sync_ff <= id_meta_ff;
        end
    end

    // ----------------------------------------
    // Cycle sequencer
    // ----------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: nxt_state = ST_IDLE;
            ST_START: nxt_state = (start_ok && id_hit) ? ST_ADDR : ST_IDLE; // [RULE_01] [RULE_02] [RULE_03] [RULE_24]
            ST_ADDR: begin
                if (nib_cnt_ff == 4'(ADDR_NIBS - 1)) nxt_state = ST_SIZE; // [RULE_04]
            end
            ST_SIZE: begin
                if (!sz_ok) begin
                    nxt_state = ST_IDLE; // [RULE_05] [RULE_06] [RULE_20]
                end else begin
                    nxt_state = is_wr_ff ? ST_WDATA : ST_RTAR0; // [RULE_23]
                end
            end
            ST_RTAR0: nxt_state = ST_RTAR1; // [RULE_07]
            ST_RTAR1: begin
                if (buf_valid) nxt_state = ST_RD_SYNC; // [RULE_08]
            end
            ST_RD_SYNC: nxt_state = ST_RDATA; // [RULE_09]
            ST_RDATA: begin
                if (hi_ff && (left_ff == 8'h01)) nxt_state = ST_TAR_OUT; // [RULE_10]
            end
            ST_WDATA: begin
                if (nib_cnt_ff == last_wnib) nxt_state = ST_WTAR0; // [RULE_12]
            end
            ST_WTAR0: nxt_state = ST_WTAR1; // [RULE_13]
            ST_WTAR1: begin
                if (pushed_all) nxt_state = ST_WSYNC; // [RULE_14]
            end
            ST_WSYNC: nxt_state = ST_TAR_OUT;
            ST_TAR_OUT: nxt_state = ST_IDLE; // [RULE_11] [RULE_15]
            default: nxt_state = ST_IDLE;
        endcase
        // Frame low always wins: abort and restart capture
        if (frame_low) nxt_state = ST_START; // [RULE_17] [RULE_18] [RULE_19]
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------
    // Field capture
    // ----------------------------------------
    // Every field is taken at the edge that closes its own clock
    always_ff @(posedge clock) begin // [RULE_16]
        if (sys_rst) begin
            start_ff <= 4'h0;
            is_wr_ff <= 1'b0;
            addr_ff <= '0;
            nib_cnt_ff <= 4'h0;
        end else begin
            if (frame_low) start_ff <= bus.lad; // [RULE_01]
            if (state_ff == ST_START) is_wr_ff <= (start_ff == START_WR); // [RULE_02]
            if (state_ff == ST_ADDR) addr_ff <= {addr_ff[ADDR_W-5:0], bus.lad}; // [RULE_04]
            if (state_ff == ST_SIZE) addr_ff <= addr_ff & align_mask; // [RULE_21]
            if ((state_ff == ST_ADDR) || (state_ff == ST_WDATA)) begin
                nib_cnt_ff <= nib_cnt_ff + 4'h1;
            end else begin
                nib_cnt_ff <= 4'h0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            byte_cnt_ff <= '0;
            skip_ff <= 1'b0;
            wdata_ff <= '0;
        end else begin
            if (state_ff == ST_SIZE) begin
                byte_cnt_ff <= nbytes; // [RULE_05]
                skip_ff <= prog_busy; // [RULE_23]
            end
            if (state_ff == ST_WDATA) wdata_ff[{nib_cnt_ff[2:0], 2'b00} +: 4] <= bus.lad; // [RULE_12]
        end
    end

    // ----------------------------------------
    // Data movement counters
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            left_ff <= '0;
            hi_ff <= 1'b0;
            push_cnt_ff <= '0;
        end else begin
            if (state_ff == ST_SIZE) begin
                left_ff <= nbytes;
                push_cnt_ff <= '0;
            end
            if (state_ff == ST_RDATA) begin
                hi_ff <= !hi_ff;
                if (hi_ff) left_ff <= left_ff - 8'h01;
            end else begin
                hi_ff <= 1'b0;
            end
            if (wr_valid && wr_ready) push_cnt_ff <= push_cnt_ff + 8'h01;
        end
    end

    // ----------------------------------------
    // Read request and abort pulses
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rd_req_ff <= 1'b0;
            cyc_abort_ff <= 1'b0;
        end else begin
            rd_req_ff <= (state_ff == ST_SIZE) && sz_ok && !is_wr_ff && !frame_low;
            // Tells the back end to drop any bytes not yet handed over
            cyc_abort_ff <= frame_low && busy_state; // [RULE_19]
        end
    end

    assign rd_req = rd_req_ff;
    assign rd_count = byte_cnt_ff;
    assign rd_flash = addr_ff[FLASH_SEL_BIT]; // [RULE_22]
    assign rd_offset = addr_ff[OFFS_W-1:0]; // [RULE_22]
    assign cyc_abort = cyc_abort_ff;

    // ----------------------------------------
    // Read byte buffer
    // ----------------------------------------
    // Flushed while idle so stale bytes from an aborted burst never leak out
    lfm_buf #(.W(8), .DEPTH(2)) u_rd_buf (
        .clock(clock),
        .sys_rst(sys_rst),
        .flush(state_ff == ST_IDLE || state_ff == ST_START),
        .in_valid(rd_valid),
        .in_ready(rd_ready),
        .in_data(rd_data),
        .out_valid(buf_valid),
        .out_ready(buf_pop),
        .out_data(buf_data)
    );

    // ----------------------------------------
    // Write byte hand-off
    // ----------------------------------------
    // A back end holding wr_ready low stalls the ready sync; prog_busy at the size clock drops the write
    assign wr_valid = in_wr_push && !skip_ff && (push_cnt_ff < bytes_have); // [RULE_23]
    assign wr_flash = addr_ff[FLASH_SEL_BIT]; // [RULE_22]
    assign wr_offset = addr_ff[OFFS_W-1:0] | OFFS_W'(push_cnt_ff);
    assign wr_data = wdata_ff[{push_cnt_ff[1:0], 3'b000} +: 8];

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    assign bus.dev_lad_oe_n = !dev_drive; // [RULE_08] [RULE_24]
    assign bus.dev_lad_o = ((state_ff == ST_RD_SYNC) || (state_ff == ST_WSYNC)) ? SYNC_READY : // [RULE_09] [RULE_14]
                           (state_ff == ST_RDATA) ? (hi_ff ? buf_data[7:4] : buf_data[3:0]) : // [RULE_10]
                           NIB_ONES; // [RULE_11] [RULE_15]
endmodule : lfm_target
`default_nettype wire

// ==== lpc_firmware_memory_target_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module lpc_firmware_memory_target_tb;
    import lfm_pkg::*;
    logic clock = 0, sys_rst = 1, cmd_valid = 0, cmd_write = 0, abort_req = 0, prog_busy = 0, wr_ready = 0;
    logic [3:0] cmd_id = 0, cmd_size = 0;
    logic [3:0] rs[5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h7};
    logic [27:0] cmd_addr = 0;
    logic [31:0] cmd_wdata = 0;
    logic [7:0] fb = 0, fl = 0, rd_count, rsp_data, rd_data, wr_data;
    logic [20:0] rd_offset, wr_offset;
    logic cmd_ready, rsp_valid, done, fail, rd_req, rd_flash, rd_valid, rd_ready, wr_valid, wr_flash, cyc_abort;
    logic [7:0] q_rd[$];
    logic [29:0] q_req[$];
    logic q_end[$];
    int n_fail = 0, n_compared = 0, n_abort = 0;
    lfm_if bus_if();
    lfm_target lfm_target_inst(.clock(clock), .sys_rst(sys_rst), .bus(bus_if.dev), .device_select_straps(4'h5),
        .rd_req(rd_req), .rd_flash(rd_flash), .rd_offset(rd_offset), .rd_count(rd_count), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_flash(wr_flash),
        .wr_offset(wr_offset), .wr_data(wr_data), .prog_busy(prog_busy), .cyc_abort(cyc_abort));
    lfm_host #(.SYNC_WAIT(8), .ABORT_LEN(2)) lfm_host_inst(.clock(clock), .sys_rst(sys_rst), .bus(bus_if.host),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_id(cmd_id), .cmd_addr(cmd_addr),
        .cmd_size(cmd_size), .cmd_wdata(cmd_wdata), .abort_req(abort_req), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .done(done), .fail(fail));
    lfm_asserts lfm_asserts_inst(.clock(clock), .sys_rst(sys_rst), .frame_n(bus_if.frame_n),
        .host_lad_o(bus_if.host_lad_o), .host_lad_oe_n(bus_if.host_lad_oe_n), .dev_lad_o(bus_if.dev_lad_o),
        .dev_lad_oe_n(bus_if.dev_lad_oe_n), .lad(bus_if.lad));
    always #5 clock = ~clock;
    // ----
    // Read byte source: pushes faster than the device drains, so the buffer fills
    // ----
    assign rd_valid = fl != 8'h0;
    assign rd_data = fb ^ 8'h3c;
    always @(posedge clock) begin
        wr_ready <= #1 ($urandom_range(3) != 0);
        if (cyc_abort) begin
            fl <= #1 8'h0;
        end else if (rd_req) begin
            fb <= #1 rd_offset[7:0];
            fl <= #1 rd_count;
        end else if (rd_valid && rd_ready) begin
            fb <= #1 fb + 8'h1;
            fl <= #1 fl - 8'h1;
        end
    end
    task automatic tally(input logic ok, input logic [29:0] got, input logic [29:0] exp);
        n_compared++;
        if (!ok) begin
            n_fail++;
            $display("unexpected result at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : tally
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        tally(got === exp, 30'(got), 30'(exp));
    endtask : chk_byte
    task automatic chk_req(input logic [29:0] got, input logic [29:0] exp);
        tally(got === exp, got, exp);
    endtask : chk_req
    task automatic chk_end(input logic got, input logic exp);
        tally(got === exp, 30'(got), 30'(exp));
    endtask : chk_end
    initial forever begin
        @(posedge clock);
        #2;
        if (rsp_valid === 1'b1) chk_byte(rsp_data, q_rd.size() ? q_rd.pop_front() : 8'hxx);
        if (rd_req === 1'b1) chk_req({rd_flash, rd_offset, rd_count}, q_req.size() ? q_req.pop_front() : 'x);
        if ((wr_valid && wr_ready) === 1'b1) chk_req({wr_flash, wr_offset, wr_data}, q_req.size() ? q_req.pop_front() : 'x);
        if ((done || fail) === 1'b1) chk_end(done, q_end.size() ? q_end.pop_front() : 1'bx);
        if (cyc_abort === 1'b1) n_abort++;
    end
    task automatic run(input logic w, input logic [3:0] id, input logic [3:0] sz, input logic ok, input logic ab);
        logic [27:0] a;
        logic [20:0] al;
        int n;
        int i;
        @(posedge clock);
        #1;
        a = 28'($urandom);
        cmd_wdata = $urandom;
        n = 1 << sz[2:0];
        al = a[20:0] & ~21'(n - 1);
        if (ok && !w) q_req.push_back({a[22], al, 8'(n)});
        for (i = 0; i < n; i++) begin
            if (ok && !w) q_rd.push_back(8'(al[7:0] + i) ^ 8'h3c);
            if (ok && w && !prog_busy) q_req.push_back({a[22], al | 21'(i), cmd_wdata[8*i+:8]});
        end
        q_end.push_back(ok);
        cmd_valid = 1;
        cmd_write = w;
        cmd_id = id;
        cmd_addr = a;
        cmd_size = sz;
        while (cmd_ready !== 1'b1) @(posedge clock) #1;
        @(posedge clock);
        #1 cmd_valid = 0;
        if (ab) begin
            repeat (4) @(posedge clock);
            #1 abort_req = 1;
        end
        n = 0;
        while (!(done === 1'b1 || fail === 1'b1) && n < 3000) begin
            @(posedge clock);
            #1 n++;
        end
        if (n >= 3000) n_fail++;
        abort_req = 0;
        repeat (3) @(posedge clock);
        #1;
    endtask : run
    task automatic finish_test();
        n_fail += q_rd.size() + q_req.size() + q_end.size();
        if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
    initial begin
        #100000;
        n_fail++;
        finish_test();
    end
    initial begin
        void'($urandom(32'h63138464));
        repeat (4) @(posedge clock);
        #1 sys_rst = 0;
        foreach (rs[k]) run(1'b0, 4'h5, rs[k], 1'b1, 1'b0);
        for (int k = 0; k < 3; k++) run(1'b1, 4'h5, 4'(k), 1'b1, 1'b0);
        run(1'b0, 4'h5, 4'h3, 1'b0, 1'b0);
        run(1'b1, 4'h5, 4'h4, 1'b0, 1'b0);
        run(1'b0, 4'ha, 4'h1, 1'b0, 1'b0);
        prog_busy = 1;
        run(1'b1, 4'h5, 4'h2, 1'b1, 1'b0);
        prog_busy = 0;
        run(1'b0, 4'h5, 4'h7, 1'b0, 1'b1);
        chk_end(n_abort != 0, 1'b1);
        run(1'b0, 4'h5, 4'h2, 1'b1, 1'b0);
        finish_test();
    end
endmodule : lpc_firmware_memory_target_tb
`default_nettype wire
